// >>> verilog/adc_vector_regs.svh
// Register offsets, field layouts, reset values and masks of the converter support block.
`ifndef ADC_VECTOR_REGS_SVH
`define ADC_VECTOR_REGS_SVH

`define ADDR_W                 8
`define OFF_ISR_TABLE_BASE     8'h00
`define OFF_PORT_ANALOG_CONFIG 8'h04
`define OFF_PAIR_STATUS        8'h08
`define OFF_IRQ_STATUS         8'h0c
`define OFF_IRQ_MASK           8'h10

`define PAIR_COUNT             7
`define CHANNEL_COUNT          12
`define INDEX_W                3
`define INDEX_SHIFT            2

`define RST_ISR_TABLE_BASE     16'h0000
`define RST_PORT_ANALOG_CONFIG 12'h000
`define RST_PAIR_FLAGS         7'h00
`define BASE_WRITE_MASK        16'hfffe
`define CHANNEL_PRESENT        12'hfff

`endif

// >>> verilog/adc_vector_pkg.sv
// Types shared by the converter support block and its submodules.
`default_nettype none
package adc_vector_pkg;
  typedef logic [15:0] half_t;
  typedef logic [31:0] word_t;
  typedef logic [6:0]  pair_vec_t;
  typedef logic [11:0] pin_vec_t;
  typedef logic [2:0]  pair_index_t;
  typedef enum {SEL_BASE, SEL_CONFIG, SEL_PAIR, SEL_IRQ_STAT, SEL_IRQ_MASK, SEL_NONE} reg_sel_t;
endpackage : adc_vector_pkg
`default_nettype wire

// >>> verilog/pair_flag_bank.sv
// Sticky per-pair flags: hardware sets, a clear strobe drops them, a set wins.
`default_nettype none
module pair_flag_bank (
  input  wire  logic                  clk,
  input  wire  logic                  rst_n,
  input  wire  adc_vector_pkg::pair_vec_t set_in,
  input  wire  adc_vector_pkg::pair_vec_t clear_in,
  output var   adc_vector_pkg::pair_vec_t flags
);
  import adc_vector_pkg::*;

  pair_vec_t flags_next;

  // One flag per pair; a set in the clearing cycle keeps the flag up.
  genvar g;
  generate
    for (g = 0; g < 7; g++) begin : gen_flag
      always_comb begin
        flags_next[g] = set_in[g] | (flags[g] & ~clear_in[g]);
      end
    end
  endgenerate

  // Registers the flags.
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      flags <= 7'h00;
    end else begin
      flags <= flags_next;
    end
  end
endmodule : pair_flag_bank
`default_nettype wire

// >>> verilog/pair_index_encoder.sv
// Priority encoder: lowest numbered set flag gives the index.
`default_nettype none
module pair_index_encoder (
  input  wire logic                      [6:0] flags,
  output var  adc_vector_pkg::pair_index_t     index,
  output var  logic                            any_set
);
  import adc_vector_pkg::*;

  // Scans from the lowest priority upward so pair zero overwrites all others.
  always_comb begin
    index   = 3'h0;
    any_set = 1'b0;
    for (int i = 6; i >= 0; i--) begin
      if (flags[i]) begin
        index   = pair_index_t'(i);
        any_set = 1'b1;
      end
    end
  end
endmodule : pair_index_encoder
`default_nettype wire

// >>> verilog/adc_vector_and_pin_config.sv
// Jump-table base, pin mode select, pair ready flags and interrupts behind an APB slave.
//
// Our own choices: the APB register port and the register addresses.
`include "adc_vector_regs.svh"
`default_nettype none
module adc_vector_and_pin_config (
  input  wire logic                      pclk,
  input  wire logic                      presetn,
  input  wire logic                [7:0] paddr,
  input  wire logic                      psel,
  input  wire logic                      penable,
  input  wire logic                      pwrite,
  input  wire adc_vector_pkg::word_t     pwdata,
  input  wire logic                [3:0] pstrb,
  output var  adc_vector_pkg::word_t     prdata,
  output var  logic                      pready,
  output var  logic                      pslverr,
  input  wire adc_vector_pkg::pair_vec_t pair_data_ready,
  input  wire adc_vector_pkg::pin_vec_t  port_pin_in,
  output var  adc_vector_pkg::pin_vec_t  pin_digital_select,
  output var  adc_vector_pkg::pin_vec_t  analog_ground_ref_select,
  output var  adc_vector_pkg::pin_vec_t  analog_sample_enable,
  output var  adc_vector_pkg::pin_vec_t  port_read_data,
  output var  adc_vector_pkg::pair_vec_t pair_result_ready,
  output var  adc_vector_pkg::pair_vec_t pair_done_irq,
  output var  logic                      irq
);
  import adc_vector_pkg::*;

  // Stored register state and its next values.
  half_t       isr_table_base_reg;
  half_t       isr_table_base_next;
  pin_vec_t    port_analog_config_reg;
  pin_vec_t    port_analog_config_next;
  pair_vec_t   irq_status_reg;
  pair_vec_t   irq_status_next;
  pair_vec_t   irq_mask_reg;
  pair_vec_t   irq_mask_next;

  // Bus answer state and its next values.
  word_t       prdata_reg;
  word_t       prdata_next;
  logic        pready_reg;
  logic        pready_next;
  logic        pslverr_reg;
  logic        pslverr_next;

  // Pin and interrupt output state.
  pin_vec_t    digital_sel_reg;
  pin_vec_t    digital_sel_next;
  pin_vec_t    ground_sel_reg;
  pin_vec_t    ground_sel_next;
  pin_vec_t    sample_en_reg;
  pin_vec_t    sample_en_next;
  pin_vec_t    port_read_reg;
  pin_vec_t    port_read_next;
  pair_vec_t   pair_irq_reg;
  pair_vec_t   pair_irq_next;
  logic        irq_reg;
  logic        irq_next;

  // Decode and handshake terms.
  reg_sel_t    sel;
  logic        setup_phase;
  logic        commit;
  logic        wr_commit;
  logic        rd_commit;
  logic        lane0;
  logic        lane1;
  pair_vec_t   ready_flags;
  pair_vec_t   ready_clear;
  pair_index_t ready_index;
  logic        ready_any;
  half_t       jump_offset;
  half_t       jump_value;
  word_t       read_word;
  pair_vec_t   status_reported;

  // Channels that this variant has; an absent channel keeps its bit at zero.
  localparam pin_vec_t CHANNEL_MASK = `CHANNEL_PRESENT;
  genvar       ch;

  // Address decode of the five words; everything else is unmapped. A stray
  // low address bit lands on no word, so a misaligned access answers an error.
  always_comb begin
    unique case (paddr)
      `OFF_ISR_TABLE_BASE:     sel = SEL_BASE;
      `OFF_PORT_ANALOG_CONFIG: sel = SEL_CONFIG;
      `OFF_PAIR_STATUS:        sel = SEL_PAIR;
      `OFF_IRQ_STATUS:         sel = SEL_IRQ_STAT;
      `OFF_IRQ_MASK:           sel = SEL_IRQ_MASK;
      default:                 sel = SEL_NONE;
    endcase
  end

  // The access phase answers once, one cycle after it starts; the
  // transfer takes effect at the edge where pready is seen high.
  // pready is cleared by its own high cycle, so a master that keeps penable
  // up for one edge too long cannot commit the same transfer twice. Every
  // access therefore costs exactly one wait state, read or write alike.
  always_comb begin
    setup_phase = psel & ~penable;
    commit      = psel & penable & pready_reg;
    wr_commit   = commit & pwrite;
    rd_commit   = commit & ~pwrite;
    lane0       = pstrb[0];
    lane1       = pstrb[1];
  end

  // Ready flags live in their own bank so that set and clear stay in one place.
  // The bank drives pair_result_ready directly, so the port is a flip-flop.
  pair_flag_bank u_ready_flags (
    .clk      (pclk),
    .rst_n    (presetn),
    .set_in   (pair_data_ready),
    .clear_in (ready_clear),
    .flags    (ready_flags)
  );

  // Writing a zero to a ready bit clears it; writing a one leaves it alone.
  // Only lane 0 carries the seven flag bits. The bank lets a data arrival
  // in the same cycle win over this clear, so no conversion is lost.
  always_comb begin
    ready_clear = 7'h00;
    if (wr_commit && sel == SEL_PAIR && lane0) begin
      ready_clear = ~pwdata[6:0];
    end
  end

  // Highest priority pending pair, pair zero first.
  // An empty flag set gives index zero with any_set low; the sum ignores it.
  pair_index_encoder u_encoder (
    .flags   (ready_flags),
    .index   (ready_index),
    .any_set (ready_any)
  );

  // Jump value: stored base plus the index moved up two places, or the
  // base alone when nothing is pending.
  // The sum wraps at 16 bits; software keeps the table clear of the top.
  // The encoded part never touches bits 1 and 0, but the stored bit 1 does.
  always_comb begin
    jump_offset = 16'h0000;
    if (ready_any) begin
      jump_offset = {11'h000, ready_index, 2'b00};
    end
    jump_value = isr_table_base_reg + jump_offset;
  end

  // Register writes. Byte lane 0 carries bits 7:0, lane 1 bits 15:8.
  // Lanes 2 and 3 carry nothing: every word keeps its data in the low half.
  // A write with neither low lane set completes but changes no state.
  always_comb begin
    isr_table_base_next     = isr_table_base_reg;
    port_analog_config_next = port_analog_config_reg;
    irq_mask_next           = irq_mask_reg;
    if (wr_commit) begin
      unique case (sel)
        SEL_BASE: begin
          if (lane0) begin
            isr_table_base_next[7:0] = pwdata[7:0] & 8'hfe;
          end
          if (lane1) begin
            isr_table_base_next[15:8] = pwdata[15:8];
          end
        end
        SEL_CONFIG: begin
          if (lane0) begin
            port_analog_config_next[7:0] = pwdata[7:0];
          end
          if (lane1) begin
            port_analog_config_next[11:8] = pwdata[11:8];
          end
        end
        SEL_IRQ_MASK: begin
          if (lane0) begin
            irq_mask_next = pwdata[6:0];
          end
        end
        SEL_PAIR, SEL_IRQ_STAT, SEL_NONE: begin
          isr_table_base_next = isr_table_base_reg;
        end
      endcase
    end
    port_analog_config_next = port_analog_config_next & `CHANNEL_PRESENT;
  end

  // Interrupt status: each data arrival is sticky until a read of the
  // status word; an arrival during that read is kept.
  // The read data were taken one edge before the commit, so a bit that rose
  // in between has not reached software yet. Only the bits that went out on
  // prdata are dropped; any other bit waits for the next read, and an arrival
  // in the commit cycle itself sets its bit again, so the set wins.
  always_comb begin
    status_reported = prdata_reg[6:0];
    irq_status_next = irq_status_reg;
    if (rd_commit && sel == SEL_IRQ_STAT) begin
      irq_status_next = irq_status_reg & ~status_reported;
    end
    irq_status_next = irq_status_next | pair_data_ready;
    // Taken from the next value, so irq rises on the edge that sets the bit.
    irq_next        = |(irq_status_next & irq_mask_reg);
  end

  // Read value of each word. Unimplemented bits come back as zero: base
  // bit zero, configuration bits 15 to 12 and the whole upper half. Only
  // the jump base, the pair flags and the status word change under software's feet, and
  // all come from flip-flops, so the value holds still for a cycle.
  always_comb begin
    unique case (sel)
      SEL_BASE:     read_word = {16'h0000, jump_value & `BASE_WRITE_MASK};
      SEL_CONFIG:   read_word = {20'h00000, port_analog_config_reg};
      SEL_PAIR:     read_word = {25'h0000000, ready_flags};
      SEL_IRQ_STAT: read_word = {25'h0000000, irq_status_reg};
      SEL_IRQ_MASK: read_word = {25'h0000000, irq_mask_reg};
      SEL_NONE:     read_word = 32'h0000_0000;
    endcase
  end

  // Bus answer: read data are prepared during the first access cycle
  // and presented with pready; unmapped addresses answer with pslverr.
  always_comb begin
    prdata_next  = prdata_reg;
    pready_next  = psel & penable & ~pready_reg;
    pslverr_next = 1'b0;
    if (setup_phase) begin
      prdata_next = 32'h0000_0000;
    end
    if (pready_next) begin
      pslverr_next = (sel == SEL_NONE);
      if (!pwrite) begin
        prdata_next = read_word;
      end
    end
    if (commit) begin
      prdata_next = 32'h0000_0000;
    end
  end

  // Pin paths, one slice per channel: a one puts the pin in digital mode
  // with its read path open and the mux input on ground; a zero lets the
  // converter sample the pin. The read path is gated here so that a floating
  // analog level never reaches the port logic.
  generate
    for (ch = 0; ch < `CHANNEL_COUNT; ch++) begin : gen_pin
      always_comb begin
        digital_sel_next[ch] = port_analog_config_reg[ch];
        ground_sel_next[ch]  = port_analog_config_reg[ch];
        sample_en_next[ch]   = ~port_analog_config_reg[ch] & CHANNEL_MASK[ch];
        port_read_next[ch]   = port_pin_in[ch] & port_analog_config_reg[ch];
      end
    end
  endgenerate

  // Per-pair completion interrupt, one cycle long, for each arrival.
  // It is not masked: the mask only gates the shared irq line.
  always_comb begin
    pair_irq_next = pair_data_ready;
  end

  // Registers of the software-visible state.
  // Reset leaves every pin in analog mode and the table base at zero, and
  // forgets any pending status together with the mask.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      isr_table_base_reg     <= `RST_ISR_TABLE_BASE;
      port_analog_config_reg <= `RST_PORT_ANALOG_CONFIG;
      irq_status_reg         <= `RST_PAIR_FLAGS;
      irq_mask_reg           <= `RST_PAIR_FLAGS;
    end else begin
      isr_table_base_reg     <= isr_table_base_next;
      port_analog_config_reg <= port_analog_config_next;
      irq_status_reg         <= irq_status_next;
      irq_mask_reg           <= irq_mask_next;
    end
  end

  // Registers of the bus answer.
  // Reset drops a transfer in flight; a master that keeps its access phase up
  // is answered at the first edge after release, with no new setup cycle.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata_reg  <= 32'h0000_0000;
      pready_reg  <= 1'b0;
      pslverr_reg <= 1'b0;
    end else begin
      prdata_reg  <= prdata_next;
      pready_reg  <= pready_next;
      pslverr_reg <= pslverr_next;
    end
  end

  // Registers of the pin and interrupt outputs.
  // Sample enables come up one edge after reset release, from the zero
  // configuration, so every pin is briefly in neither mode.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      digital_sel_reg <= 12'h000;
      ground_sel_reg  <= 12'h000;
      sample_en_reg   <= 12'h000;
      port_read_reg   <= 12'h000;
      pair_irq_reg    <= 7'h00;
      irq_reg         <= 1'b0;
    end else begin
      digital_sel_reg <= digital_sel_next;
      ground_sel_reg  <= ground_sel_next;
      sample_en_reg   <= sample_en_next;
      port_read_reg   <= port_read_next;
      pair_irq_reg    <= pair_irq_next;
      irq_reg         <= irq_next;
    end
  end

  // Outputs straight from flip-flops.
  // The ready flags already come from flip-flops inside the flag bank.
  always_comb begin
    prdata                   = prdata_reg;
    pready                   = pready_reg;
    pslverr                  = pslverr_reg;
    pin_digital_select       = digital_sel_reg;
    analog_ground_ref_select = ground_sel_reg;
    analog_sample_enable     = sample_en_reg;
    port_read_data           = port_read_reg;
    pair_result_ready        = ready_flags;
    pair_done_irq            = pair_irq_reg;
    irq                      = irq_reg;
  end
endmodule : adc_vector_and_pin_config
`default_nettype wire

// >>> sim/adc_vector_props.sv
// Concurrent checks on the ports of the converter support block.
`default_nettype none
module adc_vector_props (
  input wire logic                      pclk,
  input wire logic                      presetn,
  input wire logic                [7:0] paddr,
  input wire logic                      pwrite,
  input wire adc_vector_pkg::word_t     prdata,
  input wire logic                      pready,
  input wire logic                      pslverr,
  input wire adc_vector_pkg::pair_vec_t pair_data_ready,
  input wire adc_vector_pkg::pin_vec_t  pin_digital_select,
  input wire adc_vector_pkg::pin_vec_t  analog_ground_ref_select,
  input wire adc_vector_pkg::pin_vec_t  analog_sample_enable,
  input wire adc_vector_pkg::pin_vec_t  port_read_data,
  input wire adc_vector_pkg::pair_vec_t pair_result_ready,
  input wire adc_vector_pkg::pair_vec_t pair_done_irq
);
  import adc_vector_pkg::*;
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  // Read data and register layout on the bus.
  a_rdata_idle: assert property (!pready |-> prdata == 32'h0)
    else $error("read data not zero outside answer");
  a_base_low_zero: assert property (
    pready && !pwrite && paddr == 8'h00 |-> prdata[0] == 1'b0 && prdata[31:16] == 16'h0)
    else $error("base read bit zero or upper half not zero");
  a_cfg_high_zero: assert property (
    pready && !pwrite && paddr == 8'h04 |-> prdata[31:12] == 20'h0)
    else $error("config read high bits not zero");
  a_err_unmapped: assert property (pready && paddr > 8'h10 |-> pslverr)
    else $error("unmapped access without error");
  // Pin mode outputs follow the configuration bits.
  a_ground_digital: assert property (analog_ground_ref_select == pin_digital_select)
    else $error("ground select differs from digital select");
  a_sample_analog: assert property (
    $past(presetn) |-> analog_sample_enable == ~pin_digital_select)
    else $error("sample enable not inverse of digital select");
  a_read_gated: assert property (
    pin_digital_select == $past(pin_digital_select) |->
    (port_read_data & ~pin_digital_select) == 12'h000)
    else $error("port read open on analog pin");
  // Pair events raise the flags and completion pulses one edge later.
  a_done_pulse: assert property (
    pair_data_ready != 7'h00 |=> pair_done_irq == $past(pair_data_ready))
    else $error("completion pulse mismatch");
  a_flag_set: assert property (
    pair_data_ready != 7'h00 |=>
    (pair_result_ready & $past(pair_data_ready)) == $past(pair_data_ready))
    else $error("ready flag not set");
endmodule // adc_vector_props

bind adc_vector_and_pin_config adc_vector_props u_props (
  .pclk(pclk), .presetn(presetn), .paddr(paddr), .pwrite(pwrite), .prdata(prdata),
  .pready(pready), .pslverr(pslverr), .pair_data_ready(pair_data_ready),
  .pin_digital_select(pin_digital_select),
  .analog_ground_ref_select(analog_ground_ref_select),
  .analog_sample_enable(analog_sample_enable), .port_read_data(port_read_data),
  .pair_result_ready(pair_result_ready), .pair_done_irq(pair_done_irq)
);
`default_nettype wire

// >>> sim/adc_vector_and_pin_config_tb.sv
// Self-checking bench for the converter support block.
`default_nettype none
module adc_vector_and_pin_config_tb;
  timeunit 1ns;
  timeprecision 1ps;
  import adc_vector_pkg::*;
  typedef struct {half_t base; pair_vec_t flags;} row_t;
  logic       pclk;
  logic       presetn;
  logic [7:0] paddr;
  logic       psel;
  logic       penable;
  logic       pwrite;
  word_t      pwdata;
  logic [3:0] pstrb;
  word_t      prdata;
  logic       pready;
  logic       pslverr;
  pair_vec_t  pair_data_ready;
  pin_vec_t   port_pin_in;
  pin_vec_t   pin_digital_select;
  pin_vec_t   analog_ground_ref_select;
  pin_vec_t   analog_sample_enable;
  pin_vec_t   port_read_data;
  pair_vec_t  pair_result_ready;
  pair_vec_t  pair_done_irq;
  logic       irq;
  int         err_count = 0;
  int         check_count = 0;
  word_t      rv;
  logic       ev;
  row_t       rows[6] = '{'{16'h1235, 7'h00}, '{16'h2000, 7'h40}, '{16'h2002, 7'h48},
                          '{16'h0100, 7'h7f}, '{16'hfffc, 7'h20}, '{16'h8000, 7'h06}};

  adc_vector_and_pin_config dut (
    .pclk(pclk), .presetn(presetn), .paddr(paddr), .psel(psel), .penable(penable),
    .pwrite(pwrite), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .pair_data_ready(pair_data_ready), .port_pin_in(port_pin_in),
    .pin_digital_select(pin_digital_select),
    .analog_ground_ref_select(analog_ground_ref_select),
    .analog_sample_enable(analog_sample_enable), .port_read_data(port_read_data),
    .pair_result_ready(pair_result_ready), .pair_done_irq(pair_done_irq), .irq(irq)
  );

  // Clock at 200 MHz.
  initial begin
    pclk = 1'b0;
    forever #2.5 pclk = ~pclk;
  end

  task automatic test_done;
    if (err_count == 0 && check_count > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask

  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp) begin
      err_count++;
      $display("wrong value %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  // One APB transfer; the request is held until pready is sampled high.
  task automatic apb(input logic [7:0] a, input logic w, input word_t d,
                     output word_t r, output logic e);
    @(posedge pclk);
    psel    <= 1'b1;
    penable <= 1'b0;
    paddr   <= a;
    pwrite  <= w;
    pwdata  <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    r = prdata;
    e = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic wr(input logic [7:0] a, input word_t d);
    word_t r;
    logic  e;
    apb(a, 1'b1, d, r, e);
  endtask

  task automatic rd(input logic [7:0] a, input word_t exp, input string nm);
    word_t r;
    logic  e;
    apb(a, 1'b0, 32'h0, r, e);
    chk(nm, r, exp);
  endtask

  task automatic pulse(input pair_vec_t f);
    @(posedge pclk);
    pair_data_ready <= f;
    @(posedge pclk);
    pair_data_ready <= 7'h00;
    repeat (2) @(posedge pclk);
    #1;
  endtask

  // Stored base plus the lowest set pair number times four, wrapping at 16 bits.
  function automatic half_t exp_base(input half_t b, input pair_vec_t f);
    half_t idx;
    idx = 16'h0;
    for (int i = 6; i >= 0; i--) begin
      if (f[i]) begin
        idx = 16'(i);
      end
    end
    return (b & 16'hfffe) + (idx << 2);
  endfunction

  // Watchdog against a hung handshake.
  initial begin
    repeat (20000) @(posedge pclk);
    err_count++;
    test_done();
  end

  // Main sequence.
  initial begin
    presetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0;
    pstrb = 4'hf;
    pair_data_ready = 7'h00;
    port_pin_in = 12'ha5c;
    repeat (4) @(posedge pclk);
    presetn <= 1'b1;
    rd(8'h00, 32'h0, "base reset");
    rd(8'h04, 32'h0, "config reset");
    rd(8'h10, 32'h0, "mask reset");
    foreach (rows[i]) begin
      wr(8'h00, {16'h0, rows[i].base});
      pulse(rows[i].flags);
      rd(8'h00, {16'h0, exp_base(rows[i].base, rows[i].flags)}, "base read");
      rd(8'h08, {25'h0, rows[i].flags}, "ready flags");
      wr(8'h08, 32'h0);
      rd(8'h0c, {25'h0, rows[i].flags}, "irq status");
    end
    wr(8'h04, 32'hffff_f0f3);
    rd(8'h04, 32'h0000_00f3, "config read");
    chk("digital select", {20'h0, pin_digital_select}, 32'h0f3);
    chk("ground select", {20'h0, analog_ground_ref_select}, 32'h0f3);
    chk("sample enable", {20'h0, analog_sample_enable}, 32'hf0c);
    chk("port read", {20'h0, port_read_data}, 32'h050);
    pulse(7'h03);
    wr(8'h08, 32'h2);
    rd(8'h08, 32'h2, "partial clear");
    rd(8'h0c, 32'h3, "status clear");
    apb(8'h14, 1'b0, 32'h0, rv, ev);
    chk("unmapped error", {31'h0, ev}, 32'h1);
    wr(8'h10, 32'h4);
    pulse(7'h08);
    chk("masked irq", {31'h0, irq}, 32'h0);
    pulse(7'h04);
    chk("unmasked irq", {31'h0, irq}, 32'h1);
    rd(8'h0c, 32'h0c, "irq status");
    pulse(7'h00);
    chk("irq cleared", {31'h0, irq}, 32'h0);
    @(posedge pclk);
    pstrb <= 4'h1;
    wr(8'h00, 32'h0000_5a5b);
    pstrb <= 4'hf;
    rd(8'h00, 32'h0000_805e, "base lane write");
    @(posedge pclk);
    presetn <= 1'b0;
    @(posedge pclk);
    presetn <= 1'b1;
    rd(8'h04, 32'h0, "config after reset");
    rd(8'h08, 32'h0, "flags after reset");
    rd(8'h00, 32'h0, "base after reset");
    test_done();
  end
endmodule // adc_vector_and_pin_config_tb
`default_nettype wire
